// *** rtl/mac_defines.svh ***
/*
   Constants of the mode-based access-control block: special-register map,
   reset values, segment descriptor layout and physical memory regions.
   Assumes an 8-bit register space and a 16-bit physical address space.
*/
`ifndef MAC_DEFINES_SVH
`define MAC_DEFINES_SVH
// ==========
// register groups, by lowest address
`define MAC_SEG_LO   8'h40
`define MAC_SYS_LO   8'h48
`define MAC_TST_LO   8'h60
`define MAC_HW_LO    8'h80
// ==========
// registers held in this block
`define MAC_TBL_LO   8'h40
`define MAC_TBL_HI   8'h41
`define MAC_SEG_CNT  8'h42
`define MAC_PSH      8'h48
`define MAC_PSH_RST  8'h00
`define MAC_TBL_RST  16'h0000
`define MAC_CNT_RST  7'h00
`define MAC_PSH_SYS  7
// ==========
// descriptor: byte 0 flags, 1-2 first, 3-4 last, 5-6 offset
`define MAC_MAX_SEGS 7'h40
`define MAC_DESC_END 3'h6
`define MAC_F_SFR_R  3
`define MAC_F_SFR_W  4
// ==========
// physical regions, by last address
`define MAC_TROM_END 16'h0FFF
`define MAC_AROM_END 16'h7FFF
`define MAC_CEE_END  16'h87FF
`define MAC_AEE_END  16'hE7FF
`endif

// *** rtl/mac_pkg.sv ***
/*
   Types of the mode-based access-control block.
   Assumes nothing beyond a SystemVerilog compiler.
*/
package mac_pkg;
   // ==========
   // operations, modes, regions, walker states
   typedef enum logic [2:0] {
      MAC_OP_READ  = 3'h1,
      MAC_OP_WRITE = 3'h2,
      MAC_OP_EXEC  = 3'h4
   } mac_op_e;
   typedef enum logic [4:0] {
      MAC_MODE_BOOT = 5'h01,
      MAC_MODE_TEST = 5'h02,
      MAC_MODE_CL   = 5'h04,
      MAC_MODE_SYS  = 5'h08,
      MAC_MODE_USER = 5'h10
   } mac_mode_e;
   typedef enum logic [4:0] {
      MAC_RG_TROM = 5'h01,
      MAC_RG_AROM = 5'h02,
      MAC_RG_CEE  = 5'h04,
      MAC_RG_AEE  = 5'h08,
      MAC_RG_RAM  = 5'h10
   } mac_region_e;
   typedef enum logic [7:0] {
      MAC_ST_IDLE   = 8'h01,
      MAC_ST_FETCH  = 8'h02,
      MAC_ST_ISSUED = 8'h04,
      MAC_ST_CAPT   = 8'h08,
      MAC_ST_MATCH  = 8'h10,
      MAC_ST_ACCESS = 8'h20,
      MAC_ST_RDWAIT = 8'h40,
      MAC_ST_RDCAP  = 8'h80
   } mac_state_e;
endpackage

// *** rtl/mac_access_control.sv ***
/*
   Mode-based access control: cpu mode, segment walker with address
   translation, and special-register gate.
   Assumes a memory that returns read data the cycle after its strobe,
   and a cpu that issues one memory request at a time.
*/
`timescale 1ns/100ps
`include "mac_defines.svh"
module mac_access_control (
   input  wire logic              sys_clk,
   input  wire logic              reset_n,
   input  wire logic [1:0]        modeSel,
   output mac_pkg::mac_mode_e     cpuMode,
   input  wire logic [7:0]        regAddr,
   input  wire logic [7:0]        regWrData,
   input  wire logic              regWr,
   input  wire logic              regRd,
   output logic      [7:0]        regRdData,
   output logic                   sfrDenied,
   input  wire logic [7:0]        extSfrRdData,
   output logic                   extSfrWr,
   output logic      [7:0]        extSfrAddr,
   output logic      [7:0]        extSfrWrData,
   input  wire logic              memReq,
   input  wire mac_pkg::mac_op_e  memOp,
   input  wire logic [15:0]       memVAddr,
   input  wire logic [7:0]        memWrData,
   output logic                   memBusy,
   output logic                   memDone,
   output logic                   memDenied,
   output logic      [7:0]        memRdData,
   output logic                   phyRd,
   output logic                   phyWr,
   output logic      [15:0]       phyAddr,
   output logic      [7:0]        phyWrData,
   input  wire logic [7:0]        phyRdData
);
   import mac_pkg::*;

   // ==========
   // region and mode rights

   function automatic mac_region_e regionOf(input logic [15:0] a);
      if (a <= `MAC_TROM_END) return MAC_RG_TROM;
      if (a <= `MAC_AROM_END) return MAC_RG_AROM;
      if (a <= `MAC_CEE_END) return MAC_RG_CEE;
      if (a <= `MAC_AEE_END) return MAC_RG_AEE;
      return MAC_RG_RAM;
   endfunction

   // user falls in with system: segments already narrowed the address
   function automatic logic modeAllows(input mac_mode_e m, input mac_region_e r,
                                       input mac_op_e op);
      logic romOk;
      logic ramOk;
      logic ok;
      romOk = (op != MAC_OP_WRITE);
      ramOk = (op != MAC_OP_EXEC);
      case (m)
         MAC_MODE_BOOT: ok = (r == MAC_RG_TROM && romOk) || r == MAC_RG_CEE
                             || (r == MAC_RG_RAM && ramOk);
         MAC_MODE_TEST: ok = ((r == MAC_RG_TROM || r == MAC_RG_AROM) && romOk)
                             || r == MAC_RG_CEE || r == MAC_RG_AEE
                             || (r == MAC_RG_RAM && ramOk);
         MAC_MODE_CL:   ok = (r == MAC_RG_TROM && romOk) || r == MAC_RG_CEE;
         MAC_MODE_SYS,
         MAC_MODE_USER: ok = (r == MAC_RG_AROM && romOk) || r == MAC_RG_AEE
                             || (r == MAC_RG_RAM && ramOk);
         default:       ok = 1'b0;
      endcase
      return ok;
   endfunction

   // ==========
   // state

   logic [7:0]  psh;
   logic [15:0] tblPtr;
   logic [6:0]  segCount;
   logic        curSegSfrRd;
   logic        curSegSfrWr;
   mac_state_e  state;
   mac_state_e  next_state;
   mac_op_e     reqOp;
   mac_mode_e   reqMode;
   logic [15:0] reqAddr;
   logic [5:0]  segIdx;
   logic [2:0]  byteIdx;
   logic [55:0] desc;
   logic [15:0] physAddr;

   // ==========
   // mode

   mac_mode_e modeNow;
   assign modeNow = (modeSel == 2'h1) ? MAC_MODE_BOOT :
                    (modeSel == 2'h2) ? MAC_MODE_TEST :
                    (modeSel == 2'h3) ? MAC_MODE_CL :
                    psh[`MAC_PSH_SYS] ? MAC_MODE_SYS : MAC_MODE_USER;

   wire isSys  = (modeNow == MAC_MODE_SYS);
   wire isUser = (modeNow == MAC_MODE_USER);
   wire isCl   = (modeNow == MAC_MODE_CL);
   wire privAll = (modeNow == MAC_MODE_BOOT) || (modeNow == MAC_MODE_TEST);

   // ==========
   // register gate

   wire grpGen = (regAddr < `MAC_SEG_LO);
   wire grpSeg = (regAddr >= `MAC_SEG_LO) && (regAddr < `MAC_SYS_LO);
   wire grpSys = (regAddr >= `MAC_SYS_LO) && (regAddr < `MAC_TST_LO);
   wire grpTst = (regAddr >= `MAC_TST_LO) && (regAddr < `MAC_HW_LO);
   wire grpHw  = (regAddr >= `MAC_HW_LO);
   wire pshHit = (regAddr == `MAC_PSH);

   // status word stays readable outside privileged modes so code can see its mode
   wire rdOk = grpGen
             || (grpSeg && isSys)
             || (grpSys && (privAll || isSys || (pshHit && (isCl || isUser))))
             || (grpTst && privAll)
             || (grpHw && (!isUser || curSegSfrRd));
   wire wrOk = grpGen
             || (grpSeg && isSys)
             || (grpSys && (privAll || isSys))
             || (grpTst && privAll)
             || (grpHw && (!isUser || curSegSfrWr));

   wire ownHit = (regAddr == `MAC_TBL_LO) || (regAddr == `MAC_TBL_HI)
              || (regAddr == `MAC_SEG_CNT) || pshHit;
   wire [7:0] ownVal = (regAddr == `MAC_TBL_LO) ? tblPtr[7:0] :
                       (regAddr == `MAC_TBL_HI) ? tblPtr[15:8] :
                       (regAddr == `MAC_SEG_CNT) ? {1'b0, segCount} : psh;
   wire [7:0] rdVal = ownHit ? ownVal : extSfrRdData;
   wire       ownWr = regWr && wrOk;
   wire [6:0] cntIn = (regWrData[6:0] > `MAC_MAX_SEGS) ? `MAC_MAX_SEGS : regWrData[6:0];

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         regRdData <= 8'h00;
         sfrDenied <= 1'b0;
      end else begin
         regRdData <= (regRd && rdOk) ? rdVal : 8'h00;
         sfrDenied <= (regRd && !rdOk) || (regWr && !wrOk);
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         extSfrWr     <= 1'b0;
         extSfrAddr   <= 8'h00;
         extSfrWrData <= 8'h00;
      end else begin
         extSfrWr <= ownWr && !ownHit;
         if (ownWr && !ownHit) begin
            extSfrAddr   <= regAddr;
            extSfrWrData <= regWrData;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         psh      <= `MAC_PSH_RST;
         tblPtr   <= `MAC_TBL_RST;
         segCount <= `MAC_CNT_RST;
      end else if (ownWr) begin
         if (regAddr == `MAC_TBL_LO) tblPtr[7:0] <= regWrData;
         if (regAddr == `MAC_TBL_HI) tblPtr[15:8] <= regWrData;
         if (regAddr == `MAC_SEG_CNT) segCount <= cntIn;
         if (pshHit) psh <= regWrData;
      end
   end

   // ==========
   // segment walker decode

   wire [7:0]  dFlags  = desc[7:0];
   wire [15:0] dFirst  = desc[23:8];
   wire [15:0] dLast   = desc[39:24];
   wire [15:0] dOffset = desc[55:40];
   wire        inRange = (reqAddr >= dFirst) && (reqAddr <= dLast);
   wire        flagOk  = |(dFlags[2:0] & reqOp);
   wire        hit     = inRange && (dFlags[2:0] != 3'h0);
   wire [15:0] relocAddr = 16'(reqAddr + dOffset);
   wire [6:0]  segNext = {1'b0, segIdx} + 7'h01;
   wire        lastSeg = (segNext >= segCount);
   wire        skipSeg = (byteIdx == 3'h0) && (phyRdData[2:0] == 3'h0);
   wire [15:0] tblAddr = 16'(tblPtr + {7'h00, segIdx, 3'h0} + {13'h0000, byteIdx});
   wire        permit  = modeAllows(reqMode, regionOf(physAddr), reqOp);
   wire        takeReq = (state == MAC_ST_IDLE) && memReq;
   wire        userReq = (modeNow == MAC_MODE_USER);

   wire finishDeny = (takeReq && userReq && segCount == 7'h00)
                   || (state == MAC_ST_CAPT && skipSeg && lastSeg)
                   || (state == MAC_ST_MATCH && ((!hit && lastSeg) || (hit && !flagOk)))
                   || (state == MAC_ST_ACCESS && !permit);
   wire finishOk   = (state == MAC_ST_ACCESS && permit && reqOp == MAC_OP_WRITE)
                   || (state == MAC_ST_RDCAP);
   wire issueRd    = (state == MAC_ST_FETCH)
                   || (state == MAC_ST_ACCESS && permit && reqOp != MAC_OP_WRITE);
   wire issueWr    = (state == MAC_ST_ACCESS && permit && reqOp == MAC_OP_WRITE);

   always_comb begin
      next_state = state;
      unique case (state)
         MAC_ST_IDLE: begin
            if (memReq && !userReq) next_state = MAC_ST_ACCESS;
            else if (memReq && segCount != 7'h00) next_state = MAC_ST_FETCH;
         end
         MAC_ST_FETCH:  next_state = MAC_ST_ISSUED;
         MAC_ST_ISSUED: next_state = MAC_ST_CAPT;
         MAC_ST_CAPT: begin
            if (skipSeg && lastSeg) next_state = MAC_ST_IDLE;
            else if (skipSeg) next_state = MAC_ST_FETCH;
            else if (byteIdx == `MAC_DESC_END) next_state = MAC_ST_MATCH;
            else next_state = MAC_ST_FETCH;
         end
         MAC_ST_MATCH: begin
            if (hit && flagOk) next_state = MAC_ST_ACCESS;
            else if (hit || lastSeg) next_state = MAC_ST_IDLE;
            else next_state = MAC_ST_FETCH;
         end
         MAC_ST_ACCESS: begin
            if (permit && reqOp != MAC_OP_WRITE) next_state = MAC_ST_RDWAIT;
            else next_state = MAC_ST_IDLE;
         end
         MAC_ST_RDWAIT: next_state = MAC_ST_RDCAP;
         MAC_ST_RDCAP:  next_state = MAC_ST_IDLE;
         default:       next_state = MAC_ST_IDLE;
      endcase
   end

   // ==========
   // walker registers

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state    <= MAC_ST_IDLE;
         memBusy  <= 1'b0;
         reqOp    <= MAC_OP_READ;
         reqMode  <= MAC_MODE_BOOT;
         reqAddr  <= 16'h0000;
      end else begin
         state   <= next_state;
         memBusy <= (next_state != MAC_ST_IDLE);
         if (takeReq) begin
            reqOp   <= memOp;
            reqMode <= modeNow;
            reqAddr <= memVAddr;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         segIdx  <= 6'h00;
         byteIdx <= 3'h0;
         desc    <= 56'h00000000000000;
      end else if (state == MAC_ST_IDLE) begin
         segIdx  <= 6'h00;
         byteIdx <= 3'h0;
      end else if (state == MAC_ST_CAPT) begin
         desc    <= {phyRdData, desc[55:8]};
         byteIdx <= skipSeg ? 3'h0 : byteIdx + 3'h1;
         if (skipSeg) segIdx <= segNext[5:0];
      end else if (state == MAC_ST_MATCH) begin
         byteIdx <= 3'h0;
         segIdx  <= segNext[5:0];
      end
   end

   // privileged modes see an identity map; user goes through the segment table
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         physAddr <= 16'h0000;
      end else if (takeReq) begin
         physAddr <= memVAddr;
      end else if (state == MAC_ST_MATCH && hit && flagOk) begin
         physAddr <= relocAddr;
      end
   end

   // only an executed fetch moves the hardware-register rights, so data
   // reads from another segment cannot borrow its rights
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         curSegSfrRd <= 1'b0;
         curSegSfrWr <= 1'b0;
      end else if (issueRd && state == MAC_ST_ACCESS && reqOp == MAC_OP_EXEC) begin
         curSegSfrRd <= (reqMode == MAC_MODE_USER) && dFlags[`MAC_F_SFR_R];
         curSegSfrWr <= (reqMode == MAC_MODE_USER) && dFlags[`MAC_F_SFR_W];
      end
   end

   // ==========
   // memory and cpu strobes

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         phyRd     <= 1'b0;
         phyWr     <= 1'b0;
         phyAddr   <= 16'h0000;
         phyWrData <= 8'h00;
      end else begin
         phyRd <= issueRd;
         phyWr <= issueWr;
         if (state == MAC_ST_FETCH) phyAddr <= tblAddr;
         else if (state == MAC_ST_ACCESS) phyAddr <= physAddr;
         if (takeReq) phyWrData <= memWrData;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         memDone   <= 1'b0;
         memDenied <= 1'b0;
         memRdData <= 8'h00;
         cpuMode   <= MAC_MODE_BOOT;
      end else begin
         memDone   <= finishOk || finishDeny;
         memDenied <= finishDeny;
         if (state == MAC_ST_RDCAP) memRdData <= phyRdData;
         else if (finishDeny) memRdData <= 8'h00;
         cpuMode   <= modeNow;
      end
   end

   // ==========
   // checks

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);

   property p_mode_boot;
      modeSel == 2'h1 |=> cpuMode == MAC_MODE_BOOT;
   endproperty
   a_mode_boot: assert property (p_mode_boot)
      else $error("boot select did not give boot mode");

   property p_mode_user;
      (modeSel == 2'h0 && !psh[`MAC_PSH_SYS]) |=> cpuMode == MAC_MODE_USER;
   endproperty
   a_mode_user: assert property (p_mode_user)
      else $error("user mode not derived");

   property p_rd_zero;
      (regRd && !rdOk) |=> regRdData == 8'h00 && sfrDenied;
   endproperty
   a_rd_zero: assert property (p_rd_zero)
      else $error("refused read leaked data");

   property p_wr_drop;
      (regWr && !wrOk) |=> !extSfrWr && $stable(psh) && $stable(tblPtr) && $stable(segCount);
   endproperty
   a_wr_drop: assert property (p_wr_drop)
      else $error("refused write took effect");

   property p_seg_sys;
      ((regRd || regWr) && grpSeg && !isSys) |=> sfrDenied;
   endproperty
   a_seg_sys: assert property (p_seg_sys)
      else $error("segmentation register reached outside system mode");

   property p_gen_open;
      ((regRd || regWr) && grpGen) |=> !sfrDenied;
   endproperty
   a_gen_open: assert property (p_gen_open)
      else $error("general register refused");

   property p_user_hw;
      (regWr && grpHw && isUser && !curSegSfrWr) |=> !extSfrWr && sfrDenied;
   endproperty
   a_user_hw: assert property (p_user_hw)
      else $error("user hardware write without segment right");

   property p_pre_check;
      (state == MAC_ST_ACCESS && !permit) |=> !phyRd && !phyWr && memDone && memDenied;
   endproperty
   a_pre_check: assert property (p_pre_check)
      else $error("refused access reached memory");

   property p_skip;
      (state == MAC_ST_CAPT && skipSeg) |=> byteIdx == 3'h0 && state != MAC_ST_MATCH;
   endproperty
   a_skip: assert property (p_skip)
      else $error("disabled segment was matched");

   property p_boot_trom;
      (state == MAC_ST_ACCESS && reqMode == MAC_MODE_BOOT && physAddr <= `MAC_TROM_END
       && reqOp != MAC_OP_WRITE) |=> phyRd ##2 (memDone && !memDenied);
   endproperty
   a_boot_trom: assert property (p_boot_trom)
      else $error("boot read of test rom refused");

   property p_reloc;
      (state == MAC_ST_MATCH && hit && flagOk) |=> physAddr == $past(relocAddr)
         ##1 (!permit || phyAddr == $past(physAddr));
   endproperty
   a_reloc: assert property (p_reloc)
      else $error("relocation not applied");

   property p_walk_bound;
      state == MAC_ST_FETCH |-> {1'b0, segIdx} < segCount;
   endproperty
   a_walk_bound: assert property (p_walk_bound)
      else $error("walk beyond segment count");

   c_user_ok:   cover property (state == MAC_ST_MATCH && hit && flagOk ##1 permit);
   c_user_miss: cover property (state == MAC_ST_MATCH && !hit && lastSeg);
   c_boot_exec: cover property (issueRd && reqMode == MAC_MODE_BOOT && reqOp == MAC_OP_EXEC);
   c_sfr_deny:  cover property (regWr && grpHw && isUser && !wrOk);

endmodule

// *** tb/mac_mem_model.sv ***
/*
   Physical memory behind the access-control block: 64 KiB of bytes,
   preloaded with a pattern of address high xor address low.
   Assumes read data are wanted in the cycle after phyRd and only there.
*/
`timescale 1ns/100ps
module mac_mem_model (
   input  wire logic        sys_clk,
   input  wire logic        phyRd,
   input  wire logic        phyWr,
   input  wire logic [15:0] phyAddr,
   input  wire logic [7:0]  phyWrData,
   output logic      [7:0]  phyRdData
);
   // ==========
   // storage
   logic [7:0] mem [0:65535];
   initial begin
      for (int i = 0; i < 65536; i++) begin
         mem[i] = i[7:0] ^ i[15:8];
      end
      phyRdData = 8'h00;
   end
   // descriptor fetches and translated accesses land here
   always @(posedge sys_clk) begin
      if (phyWr) begin
         mem[phyAddr] <= phyWrData;
      end
      // outside the answer cycle the bus flips, so stale data never passes
      if (phyRd) begin
         phyRdData <= mem[phyAddr];
      end else begin
         phyRdData <= ~phyRdData;
      end
   end
endmodule

// *** tb/mac_access_control_tb.sv ***
/*
   Self-checking bench of the access-control block: register port,
   cpu modes, memory translation and refusal.
   Assumes mac_mem_model as physical memory and ~regAddr as external data.
*/
`timescale 1ns/100ps
module mac_access_control_tb;
   import mac_pkg::*;
   // ==========
   // signals
   logic             sys_clk = 1'b0;
   logic             reset_n = 1'b0;
   logic [1:0]       modeSel = 2'h0;
   mac_mode_e        cpuMode;
   logic [7:0]       regAddr = 8'h00;
   logic [7:0]       regWrData = 8'h00;
   logic             regWr = 1'b0;
   logic             regRd = 1'b0;
   logic [7:0]       regRdData;
   logic             sfrDenied;
   logic             extSfrWr;
   logic [7:0]       extSfrAddr;
   logic [7:0]       extSfrWrData;
   logic             memReq = 1'b0;
   mac_op_e          memOp = MAC_OP_READ;
   logic [15:0]      memVAddr = 16'h0000;
   logic [7:0]       memWrData = 8'h00;
   logic             memBusy;
   logic             memDone;
   logic             memDenied;
   logic [7:0]       memRdData;
   logic             phyRd;
   logic             phyWr;
   logic [15:0]      phyAddr;
   logic [7:0]       phyWrData;
   logic [7:0]       phyRdData;
   logic             hit = 1'b0;
   logic [15:0]      lastPhy = 16'h0000;
   int               errors = 0;
   int               comparisons = 0;
   logic [7:0]       tbl [0:13] = '{8'h00, 8'h00, 8'h20, 8'hFF, 8'h20, 8'h00, 8'h02,
                                    8'h0D, 8'h00, 8'h20, 8'hFF, 8'h20, 8'h00, 8'h01};
   wire logic [7:0]  extSfrRdData = ~regAddr;
   always #2 sys_clk = ~sys_clk;
   // ==========
   // instances
   mac_access_control u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .modeSel(modeSel),
      .cpuMode(cpuMode), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
      .regRd(regRd), .regRdData(regRdData), .sfrDenied(sfrDenied),
      .extSfrRdData(extSfrRdData), .extSfrWr(extSfrWr), .extSfrAddr(extSfrAddr),
      .extSfrWrData(extSfrWrData), .memReq(memReq), .memOp(memOp), .memVAddr(memVAddr),
      .memWrData(memWrData), .memBusy(memBusy), .memDone(memDone), .memDenied(memDenied),
      .memRdData(memRdData), .phyRd(phyRd), .phyWr(phyWr), .phyAddr(phyAddr),
      .phyWrData(phyWrData), .phyRdData(phyRdData));
   mac_mem_model u_mem (.sys_clk(sys_clk), .phyRd(phyRd), .phyWr(phyWr), .phyAddr(phyAddr),
      .phyWrData(phyWrData), .phyRdData(phyRdData));
   // walker reads of the table are not cpu accesses; sampled mid-cycle so a
   // strobe in the done cycle is recorded before the task looks
   always @(negedge sys_clk) begin
      if (phyWr || (phyRd && phyAddr[15:4] != 12'hE80)) begin
         hit <= 1'b1;
         lastPhy <= phyAddr;
      end
   end
   // ==========
   // tasks
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic den);
      @(posedge sys_clk) regRd <= 1'b1;
      regAddr <= a;
      @(posedge sys_clk) regRd <= 1'b0;
      @(posedge sys_clk);
      chk("regRdData", e, regRdData);
      chk("sfrDenied", den, sfrDenied);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic den,
                     input logic ext);
      @(posedge sys_clk) regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge sys_clk) regWr <= 1'b0;
      @(posedge sys_clk);
      chk("sfrDenied", den, sfrDenied);
      chk("extSfrWr", ext, extSfrWr);
   endtask
   task automatic mem(input mac_op_e op, input logic [15:0] va, input logic [7:0] wd,
                      input logic den, input logic [7:0] e, input logic [15:0] pa);
      int n;
      n = 0;
      @(posedge sys_clk) memReq <= 1'b1;
      hit = 1'b0;
      memOp <= op;
      memVAddr <= va;
      memWrData <= wd;
      @(posedge sys_clk) memReq <= 1'b0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (memDone !== 1'b1 && n < 200);
      chk("memDone", 1'b1, memDone);
      chk("memBusy", 1'b0, memBusy);
      if (!den && op == MAC_OP_WRITE) chk("phyWrData", wd, phyWrData);
      chk("memDenied", den, memDenied);
      chk("phyAccess", !den, hit);
      if (!den) chk("phyAddr", pa, lastPhy);
      if (!den && op != MAC_OP_WRITE) chk("memRdData", e, memRdData);
   endtask
   task automatic md(input logic [1:0] s, input mac_mode_e e);
      @(posedge sys_clk) modeSel <= s;
      repeat (2) @(posedge sys_clk);
      chk("cpuMode", e, cpuMode);
   endtask
   task automatic wrap_up;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // ==========
   // tests
   initial begin
      #80000;
      errors++;
      wrap_up();
   end
   initial begin
      repeat (20) @(posedge sys_clk);
      reset_n <= 1'b1;
      rd(8'h48, 8'h00, 1'b0);
      rd(8'h40, 8'h00, 1'b1);
      wr(8'h42, 8'h05, 1'b1, 1'b0);
      rd(8'h00, 8'hFF, 1'b0);
      $display("test reset_user done");
      md(2'h1, MAC_MODE_BOOT);
      md(2'h2, MAC_MODE_TEST);
      md(2'h3, MAC_MODE_CL);
      md(2'h1, MAC_MODE_BOOT);
      mem(MAC_OP_EXEC, 16'h0100, 8'h00, 1'b0, 8'h01, 16'h0100);
      wr(8'h48, 8'h80, 1'b0, 1'b0);
      md(2'h0, MAC_MODE_SYS);
      $display("test modes done");
      wr(8'h40, 8'h00, 1'b0, 1'b0);
      wr(8'h41, 8'hE8, 1'b0, 1'b0);
      wr(8'h42, 8'h50, 1'b0, 1'b0);
      rd(8'h42, 8'h40, 1'b0);
      wr(8'h42, 8'h02, 1'b0, 1'b0);
      rd(8'h41, 8'hE8, 1'b0);
      wr(8'h80, 8'h5A, 1'b0, 1'b1);
      chk("extSfrAddr", 8'h80, extSfrAddr);
      chk("extSfrWrData", 8'h5A, extSfrWrData);
      mem(MAC_OP_READ, 16'h1234, 8'h00, 1'b0, 8'h26, 16'h1234);
      mem(MAC_OP_READ, 16'h0100, 8'h00, 1'b1, 8'h00, 16'h0000);
      for (int i = 0; i < 14; i++) begin
         mem(MAC_OP_WRITE, 16'hE800 + 16'(i / 7 * 8 + i % 7), tbl[i], 1'b0, 8'h00,
             16'hE800 + 16'(i / 7 * 8 + i % 7));
      end
      $display("test system done");
      wr(8'h48, 8'h00, 1'b0, 1'b0);
      md(2'h0, MAC_MODE_USER);
      mem(MAC_OP_EXEC, 16'h2010, 8'h00, 1'b0, 8'h31, 16'h2110);
      mem(MAC_OP_WRITE, 16'h2010, 8'h77, 1'b1, 8'h00, 16'h0000);
      mem(MAC_OP_READ, 16'h20FF, 8'h00, 1'b0, 8'hDE, 16'h21FF);
      mem(MAC_OP_READ, 16'h2100, 8'h00, 1'b1, 8'h00, 16'h0000);
      rd(8'h80, 8'h7F, 1'b0);
      wr(8'h80, 8'h11, 1'b1, 1'b0);
      rd(8'h60, 8'h00, 1'b1);
      $display("test user done");
      md(2'h1, MAC_MODE_BOOT);
      wr(8'h48, 8'h80, 1'b0, 1'b0);
      md(2'h0, MAC_MODE_SYS);
      wr(8'h42, 8'h00, 1'b0, 1'b0);
      wr(8'h48, 8'h00, 1'b0, 1'b0);
      md(2'h0, MAC_MODE_USER);
      mem(MAC_OP_READ, 16'h2010, 8'h00, 1'b1, 8'h00, 16'h0000);
      $display("test no_segments done");
      wrap_up();
   end
endmodule
